// file: include/flac_pkg.sv
`default_nettype none
package flac_pkg;
   // register subaddresses
   localparam logic [7:0] ADDR_CPF_LOW = 8'h30;
   localparam logic [7:0] ADDR_CPF_MID = 8'h31;
   localparam logic [7:0] ADDR_CPF_HIGH = 8'h32;
   localparam logic [7:0] ADDR_INC_LOW = 8'h34;
   localparam logic [7:0] ADDR_INC_MID = 8'h35;
   localparam logic [7:0] ADDR_INC_HIGH = 8'h36;
   localparam logic [7:0] ADDR_BIT_DIV = 8'h38;
   localparam logic [7:0] ADDR_CH_DIV = 8'h39;
   localparam logic [7:0] ADDR_CTRL = 8'h3A;
   localparam logic [7:0] ADDR_MEAS_LOW = 8'h3C;
   localparam logic [7:0] ADDR_MEAS_MID = 8'h3D;
   localparam logic [7:0] ADDR_MEAS_HIGH = 8'h3E;
   // field widths
   localparam int CPF_W = 18;
   localparam int INC_W = 22;
   localparam int ACC_W = 23;
   localparam int DIV_W = 6;
   localparam int TRIM_W = 12;
   // control bit positions
   localparam int CTRL_BIT_EDGE = 0;
   localparam int CTRL_CH_EDGE = 1;
   localparam int CTRL_VREF_SEL = 2;
   localparam int CTRL_LOOP_OPEN = 3;
   // values after reset
   localparam logic [CPF_W-1:0] CPF_RESET = 18'h3C000;
   localparam logic [INC_W-1:0] INC_RESET = 22'h30FBCE;
   localparam logic [DIV_W-1:0] BIT_DIV_RESET = 6'h03;
   localparam logic [DIV_W-1:0] CH_DIV_RESET = 6'h10;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // trim limits of the slow loop
   localparam logic signed [TRIM_W-1:0] TRIM_MAX = 12'sh7FF;
   localparam logic signed [TRIM_W-1:0] TRIM_MIN = -12'sh7FF;
endpackage
`default_nettype wire

// file: core/flac_regs.sv
`default_nettype none
module flac_regs (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [flac_pkg::CPF_W-1:0] meas_count,
   output logic [7:0] rdata,
   output logic [flac_pkg::CPF_W-1:0] clocks_per_field,
   output logic [flac_pkg::INC_W-1:0] nominal_phase_increment,
   output logic [flac_pkg::DIV_W-1:0] bit_clock_divider_value,
   output logic [flac_pkg::DIV_W-1:0] channel_clock_divider_value,
   output logic [3:0] control
);
   // byte lane write
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         clocks_per_field <= flac_pkg::CPF_RESET;
         nominal_phase_increment <= flac_pkg::INC_RESET;
         bit_clock_divider_value <= flac_pkg::BIT_DIV_RESET;
         channel_clock_divider_value <= flac_pkg::CH_DIV_RESET;
         control <= flac_pkg::CTRL_RESET;
      end else if (wr_en) begin
         case (addr)
            flac_pkg::ADDR_CPF_LOW: clocks_per_field[7:0] <= wdata;
            flac_pkg::ADDR_CPF_MID: clocks_per_field[15:8] <= wdata;
            flac_pkg::ADDR_CPF_HIGH: clocks_per_field[17:16] <= wdata[1:0];
            flac_pkg::ADDR_INC_LOW: nominal_phase_increment[7:0] <= wdata;
            flac_pkg::ADDR_INC_MID: nominal_phase_increment[15:8] <= wdata;
            flac_pkg::ADDR_INC_HIGH: nominal_phase_increment[21:16] <= wdata[5:0];
            flac_pkg::ADDR_BIT_DIV: bit_clock_divider_value <= wdata[5:0];
            flac_pkg::ADDR_CH_DIV: channel_clock_divider_value <= wdata[5:0];
            flac_pkg::ADDR_CTRL: control <= wdata[3:0];
            default: ;
         endcase
      end
   end

   // registered read, reserved bits read zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            flac_pkg::ADDR_CPF_LOW: rdata <= clocks_per_field[7:0];
            flac_pkg::ADDR_CPF_MID: rdata <= clocks_per_field[15:8];
            flac_pkg::ADDR_CPF_HIGH: rdata <= {6'h00, clocks_per_field[17:16]};
            flac_pkg::ADDR_INC_LOW: rdata <= nominal_phase_increment[7:0];
            flac_pkg::ADDR_INC_MID: rdata <= nominal_phase_increment[15:8];
            flac_pkg::ADDR_INC_HIGH: rdata <= {2'h0, nominal_phase_increment[21:16]};
            flac_pkg::ADDR_BIT_DIV: rdata <= {2'h0, bit_clock_divider_value};
            flac_pkg::ADDR_CH_DIV: rdata <= {2'h0, channel_clock_divider_value};
            flac_pkg::ADDR_CTRL: rdata <= {4'h0, control};
            flac_pkg::ADDR_MEAS_LOW: rdata <= meas_count[7:0];
            flac_pkg::ADDR_MEAS_MID: rdata <= meas_count[15:8];
            flac_pkg::ADDR_MEAS_HIGH: rdata <= {6'h00, meas_count[17:16]};
            default: rdata <= 8'h00;
         endcase
      end
   end
endmodule // flac_regs
`default_nettype wire

// file: core/flac_clock_gen.sv
`default_nettype none
module flac_clock_gen (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic vsync_internal,
   input wire logic vref_external,
   input wire logic ext_master_clock_input,
   output logic synth_master_audio_clock,
   output logic serial_bit_clock,
   output logic left_right_channel_clock
);
   logic [flac_pkg::CPF_W-1:0] target_count;
   logic [flac_pkg::INC_W-1:0] nominal_phase_increment;
   logic [flac_pkg::DIV_W-1:0] bit_clock_divider_value;
   logic [flac_pkg::DIV_W-1:0] channel_clock_divider_value;
   logic [3:0] control;
   logic [flac_pkg::CPF_W-1:0] meas_count;
   logic bit_clock_edge_select;
   logic channel_clock_edge_select;
   logic vertical_reference_select;
   logic loop_open_select;

   assign bit_clock_edge_select = control[flac_pkg::CTRL_BIT_EDGE];
   assign channel_clock_edge_select = control[flac_pkg::CTRL_CH_EDGE];
   assign vertical_reference_select = control[flac_pkg::CTRL_VREF_SEL];
   assign loop_open_select = control[flac_pkg::CTRL_LOOP_OPEN];

   flac_regs u_regs (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .wr_en(reg_wr),
      .rd_en(reg_rd),
      .addr(reg_addr),
      .wdata(reg_wdata),
      .meas_count(meas_count),
      .rdata(reg_rdata),
      .clocks_per_field(target_count),
      .nominal_phase_increment(nominal_phase_increment),
      .bit_clock_divider_value(bit_clock_divider_value),
      .channel_clock_divider_value(channel_clock_divider_value),
      .control(control)
   );

   // synthesizer: phase accumulator on the crystal clock
   logic [flac_pkg::ACC_W-1:0] acc;
   logic [flac_pkg::ACC_W-1:0] next_acc;
   logic signed [flac_pkg::TRIM_W-1:0] trim;
   logic [23:0] inc_sum;
   logic [flac_pkg::INC_W-1:0] inc_eff;
   logic master_rise;

   assign inc_sum = {2'h0, nominal_phase_increment}
                  + {{(24 - flac_pkg::TRIM_W){trim[flac_pkg::TRIM_W-1]}}, trim};
   // saturate rather than wrap, so that a trim never jumps the rate
   assign inc_eff = inc_sum[23] ? '0
                  : (inc_sum[22] ? '1 : inc_sum[flac_pkg::INC_W-1:0]);
   assign next_acc = acc + {1'b0, inc_eff};
   assign master_rise = next_acc[flac_pkg::ACC_W-1] & ~acc[flac_pkg::ACC_W-1];

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         acc <= '0;
         synth_master_audio_clock <= 1'b0;
      end else begin
         acc <= next_acc;
         synth_master_audio_clock <= next_acc[flac_pkg::ACC_W-1];
      end
   end

   // edge pick on a sampled level and its one-cycle-old copy
   function automatic logic edge_pick(input logic now_lvl, input logic old_lvl,
                                      input logic want_rise);
      edge_pick = want_rise ? (now_lvl & ~old_lvl) : (~now_lvl & old_lvl);
   endfunction

   // field reference selection
   logic vext_s1;
   logic vext_s2;
   logic vext_prev;
   logic vint_prev;
   logic field_pulse;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         vext_s1 <= 1'b0;
         vext_s2 <= 1'b0;
         vext_prev <= 1'b0;
         vint_prev <= 1'b0;
      end else begin
         vext_s1 <= vref_external;
         vext_s2 <= vext_s1;
         vext_prev <= vext_s2;
         vint_prev <= vsync_internal;
      end
   end

   assign field_pulse = vertical_reference_select
                        ? edge_pick(vext_s2, vext_prev, 1'b1)
                        : edge_pick(vsync_internal, vint_prev, 1'b1);

   // per-field master clock count and slow trim
   logic [flac_pkg::CPF_W-1:0] field_count;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         field_count <= '0;
         meas_count <= '0;
      end else if (field_pulse) begin
         meas_count <= field_count;
         field_count <= master_rise ? 18'h00001 : 18'h00000;
      end else if (master_rise) begin
         field_count <= field_count + 18'h00001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         trim <= '0;
      end else if (loop_open_select) begin
         trim <= '0;
      end else if (field_pulse) begin
         if (field_count < target_count && trim != flac_pkg::TRIM_MAX) begin
            trim <= trim + 12'sh001;
         end else if (field_count > target_count && trim != flac_pkg::TRIM_MIN) begin
            trim <= trim - 12'sh001;
         end
      end
   end

   // master-clock input pin synchroniser and edge pick
   logic mx_s1;
   logic mx_s2;
   logic mx_prev;
   logic mx_edge;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mx_s1 <= 1'b0;
         mx_s2 <= 1'b0;
         mx_prev <= 1'b0;
      end else begin
         mx_s1 <= ext_master_clock_input;
         mx_s2 <= mx_s1;
         mx_prev <= mx_s2;
      end
   end

   assign mx_edge = edge_pick(mx_s2, mx_prev, bit_clock_edge_select);

   // bit clock divider
   logic [flac_pkg::DIV_W-1:0] bdiv_cnt;
   logic [flac_pkg::DIV_W-1:0] bdiv_lim;
   logic bit_toggle;
   logic ch_edge;

   assign bit_toggle = mx_edge && (bdiv_cnt == bdiv_lim);
   assign ch_edge = bit_toggle && (channel_clock_edge_select ? ~serial_bit_clock
                                                             : serial_bit_clock);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bdiv_cnt <= '0;
         bdiv_lim <= flac_pkg::BIT_DIV_RESET;
         serial_bit_clock <= 1'b0;
      end else if (mx_edge) begin
         if (bdiv_cnt == bdiv_lim) begin
            bdiv_cnt <= '0;
            bdiv_lim <= bit_clock_divider_value;
            serial_bit_clock <= ~serial_bit_clock;
         end else begin
            bdiv_cnt <= bdiv_cnt + 6'h01;
         end
      end
   end

   // channel clock divider, halts while its divider is zero
   logic [flac_pkg::DIV_W-1:0] ldiv_cnt;
   logic [flac_pkg::DIV_W-1:0] ldiv_lim;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ldiv_cnt <= '0;
         ldiv_lim <= flac_pkg::CH_DIV_RESET;
         left_right_channel_clock <= 1'b0;
      end else if (ch_edge) begin
         if (ldiv_lim == 6'h00) begin
            ldiv_cnt <= '0;
            ldiv_lim <= channel_clock_divider_value;
         end else if (ldiv_cnt == ldiv_lim - 6'h01) begin
            ldiv_cnt <= '0;
            ldiv_lim <= channel_clock_divider_value;
            left_right_channel_clock <= ~left_right_channel_clock;
         end else begin
            ldiv_cnt <= ldiv_cnt + 6'h01;
         end
      end
   end

   // checks
   a_bit_edge_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(serial_bit_clock) |-> $past(mx_edge))
      else $error("bit clock moved without selected input edge");

   a_bit_wrap_only: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(serial_bit_clock) |-> $past(bit_toggle))
      else $error("bit clock toggled before divider wrap");

   a_bit_lim_reload: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(bdiv_lim) |-> $changed(serial_bit_clock))
      else $error("bit divider reloaded outside wrap");

   a_ch_edge_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(left_right_channel_clock) |->
      $past(bit_toggle) && ($past(serial_bit_clock) != $past(channel_clock_edge_select)))
      else $error("channel clock moved on wrong bit clock edge");

   a_ch_zero_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ldiv_lim == 6'h00) |=> $stable(left_right_channel_clock))
      else $error("channel clock toggled with zero divider");

   a_open_no_trim: assert property (@(posedge clk_sys) disable iff (!resetn)
      loop_open_select |=> (trim == 12'sh000))
      else $error("trim not cleared with loop open");

   a_trim_up: assert property (@(posedge clk_sys) disable iff (!resetn)
      (field_pulse && !loop_open_select && field_count < target_count
       && trim != flac_pkg::TRIM_MAX) |=> (trim == $past(trim) + 12'sh001))
      else $error("trim did not rise on short field");

   a_trim_slow: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!field_pulse && !loop_open_select) |=> $stable(trim))
      else $error("trim moved between fields");

   a_field_meas: assert property (@(posedge clk_sys) disable iff (!resetn)
      field_pulse |=> (meas_count == $past(field_count)))
      else $error("field count not captured at field reference");

   a_trim_down: assert property (@(posedge clk_sys) disable iff (!resetn)
      (field_pulse && !loop_open_select && field_count > target_count
       && trim != flac_pkg::TRIM_MIN) |=> (trim == $past(trim) - 12'sh001))
      else $error("trim did not fall on long field");

   a_trim_bounded: assert property (@(posedge clk_sys) disable iff (!resetn)
      (trim <= flac_pkg::TRIM_MAX) && (trim >= flac_pkg::TRIM_MIN))
      else $error("trim outside its limits");

   a_open_nominal: assert property (@(posedge clk_sys) disable iff (!resetn)
      ($past(loop_open_select) && loop_open_select) |-> (inc_eff == nominal_phase_increment))
      else $error("open loop increment differs from nominal");

   a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!field_pulse && master_rise) |=> (field_count == $past(field_count) + 18'h00001))
      else $error("master clock rise not counted");

   a_field_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
      field_pulse |=> (field_count == ($past(master_rise) ? 18'h00001 : 18'h00000)))
      else $error("field count not restarted at field reference");

   a_meas_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      !field_pulse |=> $stable(meas_count))
      else $error("measured count moved between fields");

   a_ext_ref_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
      (vertical_reference_select && field_pulse) |-> !$past(vext_s2))
      else $error("external field pulse without rising reference");

   a_bit_cnt_range: assert property (@(posedge clk_sys) disable iff (!resetn)
      bdiv_cnt <= bdiv_lim)
      else $error("bit divider count past its limit");

   a_ch_cnt_range: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ldiv_lim != 6'h00) |-> (ldiv_cnt < ldiv_lim))
      else $error("channel divider count past its limit");

   a_ch_wrap_only: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(left_right_channel_clock) |->
      ($past(ch_edge) && $past(ldiv_lim) != 6'h00 && $past(ldiv_cnt) == $past(ldiv_lim) - 6'h01))
      else $error("channel clock toggled before divider wrap");

   a_ch_lim_reload: assert property (@(posedge clk_sys) disable iff (!resetn)
      $changed(ldiv_lim) |-> $past(ch_edge))
      else $error("channel divider reloaded outside wrap");
endmodule // flac_clock_gen
`default_nettype wire

// file: testbench/flac_codec_model.sv
`default_nettype none
module flac_codec_model #(
   parameter int HALF_NS = 40
) (
   input wire logic synth_master_audio_clock,
   input wire logic use_clean,
   output logic ext_master_clock_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clean;
   // free-running cleaned master clock from an outboard analog loop
   initial begin
      clean = 1'b0;
      forever #(HALF_NS) clean = ~clean;
   end
   // board strap: synth output straight back, or the cleaned clock
   assign ext_master_clock_input = use_clean ? clean : synth_master_audio_clock;
endmodule // flac_codec_model
`default_nettype wire

// file: testbench/field_locked_audio_clock_gen_bench.sv
`default_nettype none
module field_locked_audio_clock_gen_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, resetn, reg_wr, reg_rd, vsync_internal, vref_external, use_clean;
   logic mclk, synth_clk, bit_clk, ch_clk, prev;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic [17:0] m;
   int n_mismatch, n_tests, n, k, e;
   longint inc;
   logic [7:0] addrs [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
   logic [7:0] inits [9] = '{8'h00, 8'hC0, 8'h03, 8'hCE, 8'hFB, 8'h30, 8'h03, 8'h10, 8'h00};
   logic [7:0] masks [9] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F};
   int divs [3] = '{0, 3, 63};
   int cdivs [3] = '{1, 16, 63};

   flac_clock_gen flac_clock_gen_inst (
      .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .vsync_internal(vsync_internal), .vref_external(vref_external),
      .ext_master_clock_input(mclk), .synth_master_audio_clock(synth_clk),
      .serial_bit_clock(bit_clk), .left_right_channel_clock(ch_clk)
   );
   flac_codec_model flac_codec_model_inst (
      .synth_master_audio_clock(synth_clk), .use_clean(use_clean),
      .ext_master_clock_input(mclk)
   );

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // internal field pulse every 2001 cycles
   initial begin
      vsync_internal = 1'b0;
      forever begin
         repeat (2000) @(posedge clk_sys);
         #1 vsync_internal = 1'b1;
         @(posedge clk_sys);
         #1 vsync_internal = 1'b0;
      end
   end
   // external reference, unrelated in phase, about 1000 cycles
   initial begin
      vref_external = 1'b0;
      forever #4001 vref_external = ~vref_external;
   end

   task print_verdict;
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task check(input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // counts selected source edges in one output half period
   task half(input bit which, input bit sel, input bit armed, output int cnt);
      logic pa, po, a, o, ok;
      int t;
      bit run;
      run = armed;
      cnt = 0;
      ok = 1'b1;
      pa = which ? bit_clk : mclk;
      po = which ? ch_clk : bit_clk;
      for (t = 0; t < 20000; t++) begin
         @(negedge clk_sys);
         a = which ? bit_clk : mclk;
         o = which ? ch_clk : bit_clk;
         if (a != pa) begin
            ok = (a == sel);
            if (ok)
               cnt++;
         end
         if (o != po) begin
            if (run)
               break;
            run = 1'b1;
            cnt = 0;
         end
         pa = a;
         po = o;
      end
      if (t == 20000)
         cnt = -1;
      check(18'(ok), 18'h1);
   endtask

   task meas(input longint lo, input longint hi);
      rd(8'h3C, rv);
      m[7:0] = rv;
      rd(8'h3D, rv);
      m[15:8] = rv;
      rd(8'h3E, rv);
      m[17:16] = rv[1:0];
      check(18'(m >= lo && m <= hi), 18'h1);
   endtask

   initial begin
      #600000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      use_clean = 1'b1;
      prev = 1'b0;
      repeat (12) @(posedge clk_sys);
      #1 resetn = 1'b1;
      for (k = 0; k < 9; k++) begin
         rd(addrs[k], rv);
         check(18'(rv), 18'(inits[k]));
      end
      for (k = 0; k < 9; k++) begin
         wr(addrs[k], 8'hFF);
         rd(addrs[k], rv);
         check(18'(rv), 18'(masks[k]));
      end
      wr(8'h33, 8'hFF);
      rd(8'h33, rv);
      check(18'(rv), 18'h0);
      wr(8'h34, 8'hCE);
      wr(8'h35, 8'hFB);
      wr(8'h36, 8'h30);
      wr(8'h3A, 8'h08);
      inc = 64'h30FBCE;
      @(negedge clk_sys);
      prev = synth_clk;
      n = 0;
      for (k = 0; k < 2000; k++) begin
         @(negedge clk_sys);
         if (synth_clk && !prev)
            n++;
         prev = synth_clk;
      end
      check(18'(n >= (2000 * inc) >> 23 && n <= ((2000 * inc) >> 23) + 1), 18'h1);
      for (e = 0; e < 2; e++) begin
         for (k = 0; k < 3; k++) begin
            wr(8'h3A, 8'h08 | 8'(e));
            wr(8'h38, 8'(divs[k]));
            half(1'b0, e[0], 1'b0, n);
            half(1'b0, e[0], 1'b0, n);
            check(18'(n), 18'(divs[k] + 1));
         end
      end
      wr(8'h38, 8'h00);
      for (e = 0; e < 2; e++) begin
         for (k = 0; k < 3; k++) begin
            wr(8'h3A, 8'h08 | 8'(e << 1));
            wr(8'h39, 8'(cdivs[k]));
            half(1'b1, e[0], 1'b0, n);
            half(1'b1, e[0], 1'b0, n);
            check(18'(n), 18'(cdivs[k]));
         end
      end
      wr(8'h39, 8'h00);
      repeat (1400) @(negedge clk_sys);
      prev = ch_clk;
      n = 0;
      for (k = 0; k < 1400; k++) begin
         @(negedge clk_sys);
         if (ch_clk != prev)
            n++;
         prev = ch_clk;
      end
      check(18'(n), 18'h0);
      wr(8'h3A, 8'h09);
      wr(8'h38, 8'h03);
      half(1'b0, 1'b1, 1'b0, n);
      half(1'b0, 1'b1, 1'b0, n);
      wr(8'h38, 8'h00);
      half(1'b0, 1'b1, 1'b1, n);
      check(18'(n), 18'h4);
      half(1'b0, 1'b1, 1'b0, n);
      check(18'(n), 18'h1);
      #1 use_clean = 1'b0;
      wr(8'h34, 8'h00);
      wr(8'h35, 8'h00);
      wr(8'h36, 8'h10);
      wr(8'h38, 8'h01);
      half(1'b0, 1'b1, 1'b0, n);
      half(1'b0, 1'b1, 1'b0, n);
      check(18'(n), 18'h2);
      #1 use_clean = 1'b1;
      wr(8'h34, 8'hCE);
      wr(8'h35, 8'hFB);
      wr(8'h36, 8'h30);
      wr(8'h3A, 8'h00);
      repeat (8004) @(posedge clk_sys);
      meas((2001 * inc) >> 23, ((2001 * inc) >> 23) + 1);
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h00);
      wr(8'h32, 8'h00);
      wr(8'h3A, 8'h04);
      repeat (5000) @(posedge clk_sys);
      meas((1000 * inc) >> 23, ((1001 * inc) >> 23) + 1);
      print_verdict();
   end
endmodule // field_locked_audio_clock_gen_bench
`default_nettype wire
